// file: design/rom_check_if.sv
// Handshake between the command sequencer and the ROM checksum engine
`default_nettype none
interface rom_check_if;
	logic start;
	logic busy;
	logic done;
	logic pass;
	modport requester(output start, input busy, input done, input pass);
	modport engine(input start, output busy, output done, output pass);
endinterface
`default_nettype wire

// file: design/rom_checksum.sv
// ROM checksum engine for the self-test query
`include "status_byte_defs.svh"
`default_nettype none
module rom_checksum (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Request and result
	rom_check_if.engine chk
);
	typedef struct packed {
		status_byte_pkg::tst_state_type st;
		logic [`ROM_ADDR_W-1:0] addr;
		logic [7:0] sum;
		logic pass;
		logic done;
	} rc_state_type;

	rc_state_type s_r;
	rc_state_type s_nxt;
	logic [7:0] rom_mem [`ROM_WORDS];

	// Fixed contents; words sum to the expected value
	always_comb begin
		for (int i = 0; i < `ROM_WORDS; i++) begin
			rom_mem[i] = (i[0]) ? 8'h5a : 8'ha6;
		end
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		unique case (s_r.st)
			status_byte_pkg::TST_IDLE: begin
				if (chk.start) begin
					s_nxt.st = status_byte_pkg::TST_SUM;
					s_nxt.addr = '0;
					s_nxt.sum = `ROM_SUM_INIT;
				end
			end
			status_byte_pkg::TST_SUM: begin
				s_nxt.sum = s_r.sum + rom_mem[s_r.addr];
				s_nxt.addr = s_r.addr + 1'b1;
				if (s_r.addr == `ROM_ADDR_W'(`ROM_WORDS - 1)) begin
					s_nxt.st = status_byte_pkg::TST_DONE;
				end
			end
			status_byte_pkg::TST_DONE: begin
				s_nxt.pass = (s_r.sum == `ROM_SUM_EXPECT);
				s_nxt.done = 1'b1;
				s_nxt.st = status_byte_pkg::TST_IDLE;
			end
			default: s_nxt.st = status_byte_pkg::TST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign chk.busy = (s_r.st != status_byte_pkg::TST_IDLE);
	assign chk.done = s_r.done;
	assign chk.pass = s_r.pass;

	done_after_sum_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		s_r.st == status_byte_pkg::TST_DONE |=> chk.done)
		else $error("checksum finish did not report done");
endmodule
`default_nettype wire

// file: design/status_byte_defs.svh
// Bit positions, reset values, ROM checksum figures and self-test codes of the status byte logic
`ifndef STATUS_BYTE_DEFS_SVH
`define STATUS_BYTE_DEFS_SVH

`define SB_MEAS_BIT 0
`define SB_UNUSED_BIT 1
`define SB_ERR_BIT 2
`define SB_QUES_BIT 3
`define SB_MAV_BIT 4
`define SB_ESB_BIT 5
`define SB_MSS_BIT 6
`define SB_OPER_BIT 7
`define SB_ENABLE_RESET 8'h00
`define SB_ENABLE_MASK 8'hbf
`define ROM_WORDS 16
`define ROM_ADDR_W 4
`define ROM_SUM_INIT 8'h00
`define ROM_SUM_EXPECT 8'h00
`define TST_PASS_CODE 8'h30
`define TST_FAIL_CODE 8'h31

`endif

// file: design/status_byte_pkg.sv
// Types shared by the status byte logic
`default_nettype none
package status_byte_pkg;
	typedef enum logic [1:0] {
		CMD_SEQ,
		CMD_INIT,
		CMD_TRG,
		CMD_WAI
	} cmd_kind_type;
	typedef enum logic [1:0] {
		TST_IDLE,
		TST_SUM,
		TST_DONE
	} tst_state_type;
endpackage
`default_nettype wire

// file: design/status_byte_sync_control.sv
// Status byte, service request, bus trigger, self-test and wait-to-continue control
`include "status_byte_defs.svh"
`default_nettype none
module status_byte_sync_control (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Summary sources from event registers and queues
	input wire logic meas_summary_i,
	input wire logic error_queue_nonempty_i,
	input wire logic questionable_summary_i,
	input wire logic output_queue_nonempty_i,
	input wire logic std_event_summary_i,
	input wire logic operation_summary_i,
	// Enable register write and read
	input wire logic enable_wr_i,
	input wire logic [7:0] enable_data_i,
	output logic [7:0] enable_o,
	// Status byte query and serial poll
	input wire logic stb_query_i,
	output logic [7:0] stb_data_o,
	output logic stb_valid_o,
	output logic [7:0] service_summary_byte_o,
	output logic service_request_o,
	// Parsed command stream
	input wire logic cmd_valid_i,
	input wire status_byte_pkg::cmd_kind_type cmd_kind_i,
	input wire logic cmd_self_test_i,
	output logic cmd_ready_o,
	input wire logic seq_done_i,
	// Bus group execute trigger and trigger model
	input wire logic bus_get_i,
	input wire logic source_is_bus_i,
	input wire logic model_idle_i,
	input wire logic pointer_settled_i,
	output logic bus_trigger_o,
	output logic initiate_o,
	// Output queue feed
	output logic oq_push_o,
	output logic [7:0] oq_data_o
);
	typedef struct packed {
		logic [7:0] enable;
		logic [7:0] stb_data;
		logic stb_valid;
		logic seq_busy;
		logic init_pending;
		logic trg_pending;
		logic waiting;
		logic tst_busy;
		logic tst_start;
		logic oq_push;
		logic [7:0] oq_data;
		logic bus_trig;
		logic initiate;
		logic [1:0] get_sync;
	} ctl_state_type;

	ctl_state_type s_r;
	ctl_state_type s_nxt;
	logic [7:0] summary;
	logic mss;
	logic overlapped_busy;
	logic accept;
	logic get_seen;
	rom_check_if chk ();

	rom_checksum u_rom_checksum (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.chk(chk)
	);

	function automatic logic master_summary(input logic [7:0] sb, input logic [7:0] en);
		master_summary = |(sb & en & `SB_ENABLE_MASK);
	endfunction

	// Summary bits follow their sources; nothing in here stores them
	always_comb begin
		summary = 8'h00;
		summary[`SB_MEAS_BIT] = meas_summary_i;
		summary[`SB_UNUSED_BIT] = 1'b0;
		summary[`SB_ERR_BIT] = error_queue_nonempty_i;
		summary[`SB_QUES_BIT] = questionable_summary_i;
		summary[`SB_MAV_BIT] = output_queue_nonempty_i;
		summary[`SB_ESB_BIT] = std_event_summary_i;
		summary[`SB_OPER_BIT] = operation_summary_i;
		mss = master_summary(summary, s_r.enable);
		summary[`SB_MSS_BIT] = mss;
	end

	// Only overlapped work counts here; sequential work blocks via seq_busy and tst_busy
	assign overlapped_busy = s_r.init_pending | s_r.trg_pending;
	assign cmd_ready_o = !s_r.seq_busy && !s_r.tst_busy && !s_r.waiting;
	assign accept = cmd_valid_i && cmd_ready_o;
	assign get_seen = s_r.get_sync[1];

	always_comb begin
		s_nxt = s_r;
		s_nxt.stb_valid = 1'b0;
		s_nxt.tst_start = 1'b0;
		s_nxt.oq_push = 1'b0;
		s_nxt.bus_trig = 1'b0;
		s_nxt.initiate = 1'b0;
		// Pin trigger is asynchronous to the clock
		s_nxt.get_sync = {s_r.get_sync[0], bus_get_i};
		if (enable_wr_i) begin
			s_nxt.enable = enable_data_i & `SB_ENABLE_MASK;
		end
		if (stb_query_i) begin
			s_nxt.stb_data = summary;
			s_nxt.stb_valid = 1'b1;
		end
		if (s_r.seq_busy && seq_done_i) begin
			s_nxt.seq_busy = 1'b0;
		end
		if (s_r.init_pending && model_idle_i && !s_r.initiate) begin
			s_nxt.init_pending = 1'b0;
		end
		if (s_r.trg_pending && pointer_settled_i && !s_r.bus_trig) begin
			s_nxt.trg_pending = 1'b0;
		end
		if (s_r.waiting && !overlapped_busy) begin
			s_nxt.waiting = 1'b0;
		end
		// Group execute trigger takes the same path as the trigger command
		if (get_seen && source_is_bus_i) begin
			s_nxt.bus_trig = 1'b1;
			s_nxt.trg_pending = 1'b1;
		end
		if (accept) begin
			if (cmd_self_test_i) begin
				s_nxt.tst_busy = 1'b1;
				s_nxt.tst_start = 1'b1;
			end else begin
				unique case (cmd_kind_i)
					status_byte_pkg::CMD_SEQ: s_nxt.seq_busy = 1'b1;
					status_byte_pkg::CMD_INIT: begin
						s_nxt.initiate = 1'b1;
						s_nxt.init_pending = 1'b1;
					end
					status_byte_pkg::CMD_TRG: begin
						if (source_is_bus_i) begin
							s_nxt.bus_trig = 1'b1;
							s_nxt.trg_pending = 1'b1;
						end
					end
					status_byte_pkg::CMD_WAI: s_nxt.waiting = overlapped_busy;
				endcase
			end
		end
		if (s_r.tst_busy && chk.done) begin
			s_nxt.tst_busy = 1'b0;
			s_nxt.oq_push = 1'b1;
			s_nxt.oq_data = chk.pass ? `TST_PASS_CODE : `TST_FAIL_CODE;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_r <= '0;
			s_r.enable <= `SB_ENABLE_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign chk.start = s_r.tst_start;
	assign enable_o = s_r.enable;
	assign stb_data_o = s_r.stb_data;
	assign stb_valid_o = s_r.stb_valid;
	assign service_summary_byte_o = summary;
	assign service_request_o = mss;
	assign bus_trigger_o = s_r.bus_trig;
	assign initiate_o = s_r.initiate;
	assign oq_push_o = s_r.oq_push;
	assign oq_data_o = s_r.oq_data;

	// Query answer
	query_returns_byte_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		stb_query_i |=> stb_valid_o && stb_data_o == $past(summary))
		else $error("status byte query returned wrong value");
	query_valid_only_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!stb_query_i |=> !stb_valid_o)
		else $error("status byte answer without a query");
	stb_data_holds_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!stb_query_i |=> $stable(stb_data_o))
		else $error("status byte answer changed without a query");
	unused_bit_zero_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!service_summary_byte_o[`SB_UNUSED_BIT])
		else $error("unused status bit set");

	// Each source summary bit mirrors its source in the same cycle; MSS and service request come from the enabled bits
	meas_bit_tracks_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		service_summary_byte_o[`SB_MEAS_BIT] == meas_summary_i)
		else $error("measurement bit does not track its source");
	error_bit_tracks_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		service_summary_byte_o[`SB_ERR_BIT] == error_queue_nonempty_i)
		else $error("error bit does not track queue");
	ques_bit_tracks_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		service_summary_byte_o[`SB_QUES_BIT] == questionable_summary_i)
		else $error("questionable bit does not track its source");
	mav_bit_tracks_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		service_summary_byte_o[`SB_MAV_BIT] == output_queue_nonempty_i)
		else $error("message bit does not track output queue");
	esb_bit_tracks_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		service_summary_byte_o[`SB_ESB_BIT] == std_event_summary_i)
		else $error("standard event bit does not track its source");
	oper_bit_tracks_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		service_summary_byte_o[`SB_OPER_BIT] == operation_summary_i)
		else $error("operation bit does not track its source");
	mss_follows_enable_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		service_summary_byte_o[`SB_MSS_BIT] ==
		|(service_summary_byte_o & enable_o & `SB_ENABLE_MASK))
		else $error("master summary bit wrong");
	enable_bit6_zero_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!enable_o[`SB_MSS_BIT])
		else $error("enable bit of master summary set");
	srq_on_enabled_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(|(enable_o & {error_queue_nonempty_i, 7'h00} >> 5)) |-> service_request_o)
		else $error("enabled error bit did not request service");
	srq_is_mss_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		service_request_o == service_summary_byte_o[`SB_MSS_BIT])
		else $error("service request differs from master summary");

	// Triggers, overlapped work and sequential work
	trigger_gated_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		accept && !cmd_self_test_i && cmd_kind_i == status_byte_pkg::CMD_TRG
		&& !source_is_bus_i && !get_seen |=> !bus_trigger_o)
		else $error("trigger acted with non-bus source");
	trg_pulse_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		accept && !cmd_self_test_i && cmd_kind_i == status_byte_pkg::CMD_TRG
		&& source_is_bus_i |=> bus_trigger_o && s_r.trg_pending)
		else $error("trigger command did not fire the bus trigger");
	get_trigger_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		get_seen && source_is_bus_i |=> bus_trigger_o && s_r.trg_pending)
		else $error("group execute trigger did not fire the bus trigger");
	init_pulse_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		accept && !cmd_self_test_i && cmd_kind_i == status_byte_pkg::CMD_INIT
		|=> initiate_o && s_r.init_pending)
		else $error("initiate command did not start overlapped work");
	wait_blocks_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		s_r.waiting && overlapped_busy |-> !cmd_ready_o)
		else $error("commands accepted while waiting");
	wait_release_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		$fell(s_r.waiting) |-> !$past(overlapped_busy))
		else $error("wait released with overlapped work pending");
	seq_blocks_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		accept && !cmd_self_test_i && cmd_kind_i == status_byte_pkg::CMD_SEQ
		|=> !cmd_ready_o)
		else $error("sequential command did not block");
	seq_holds_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		s_r.seq_busy || s_r.tst_busy |-> !cmd_ready_o)
		else $error("command accepted during sequential work");
	init_done_idle_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		$fell(s_r.init_pending) |-> $past(model_idle_i))
		else $error("initiate completed outside idle");
	init_held_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		s_r.init_pending && !model_idle_i |=> s_r.init_pending)
		else $error("initiate completed while model busy");
	trg_done_settled_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		$fell(s_r.trg_pending) |-> $past(pointer_settled_i))
		else $error("trigger completed before pointer settled");
	trg_held_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		s_r.trg_pending && !pointer_settled_i |=> s_r.trg_pending)
		else $error("trigger completed while pointer moving");

	// Self-test result
	selftest_result_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		accept && cmd_self_test_i |-> ##[3:40] oq_push_o)
		else $error("self-test result never queued");
	selftest_code_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		oq_push_o |-> (oq_data_o == `TST_PASS_CODE) == $past(chk.pass))
		else $error("self-test code does not match checksum outcome");

	cover_query_c: cover property (@(posedge clk_i) stb_query_i ##1 stb_data_o[`SB_MSS_BIT]);
	cover_wait_c: cover property (@(posedge clk_i) s_r.waiting ##[1:20] !s_r.waiting);
	cover_trig_c: cover property (@(posedge clk_i) bus_trigger_o ##[1:20] !s_r.trg_pending);
	cover_tst_c: cover property (@(posedge clk_i) oq_push_o);
	cover_get_c: cover property (@(posedge clk_i) get_seen && source_is_bus_i);
endmodule
`default_nettype wire

// file: dv/status_byte_sync_control_bench.sv
// Self-checking bench of the status byte and command sync control
`default_nettype none
module status_byte_sync_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0, reset_n_i = 1'b0, enable_wr_i = 1'b0, stb_query_i = 1'b0;
	logic cmd_valid_i = 1'b0, cmd_self_test_i = 1'b0, seq_done_i = 1'b0, bus_get_i = 1'b0;
	logic source_is_bus_i = 1'b0, model_idle_i, pointer_settled_i, stb_valid_o;
	logic service_request_o, cmd_ready_o, bus_trigger_o, initiate_o, oq_push_o;
	logic [5:0] src = 6'h00;
	logic [7:0] enable_data_i = 8'h00, en = 8'h00;
	logic [7:0] enable_o, stb_data_o, service_summary_byte_o, oq_data_o;
	logic [31:0] r;
	status_byte_pkg::cmd_kind_type cmd_kind_i = status_byte_pkg::CMD_SEQ;
	logic [7:0] exp_q[$];
	int n_errors = 0, samples_checked = 0, n_trg = 0, n_init = 0, cycles = 0;
	always #2.5 clk_i = ~clk_i;
	status_byte_sync_control i_status_byte_sync_control (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .meas_summary_i(src[0]),
		.error_queue_nonempty_i(src[1]), .questionable_summary_i(src[2]),
		.output_queue_nonempty_i(src[3]), .std_event_summary_i(src[4]),
		.operation_summary_i(src[5]), .enable_wr_i(enable_wr_i), .enable_data_i(enable_data_i),
		.enable_o(enable_o), .stb_query_i(stb_query_i), .stb_data_o(stb_data_o),
		.stb_valid_o(stb_valid_o), .service_summary_byte_o(service_summary_byte_o),
		.service_request_o(service_request_o), .cmd_valid_i(cmd_valid_i), .cmd_kind_i(cmd_kind_i),
		.cmd_self_test_i(cmd_self_test_i), .cmd_ready_o(cmd_ready_o), .seq_done_i(seq_done_i),
		.bus_get_i(bus_get_i), .source_is_bus_i(source_is_bus_i), .model_idle_i(model_idle_i),
		.pointer_settled_i(pointer_settled_i), .bus_trigger_o(bus_trigger_o),
		.initiate_o(initiate_o), .oq_push_o(oq_push_o), .oq_data_o(oq_data_o));
	trigger_model_stub i_trigger_model_stub (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .initiate_i(initiate_o), .trigger_i(bus_trigger_o),
		.model_idle_o(model_idle_i), .pointer_settled_o(pointer_settled_i));
	task automatic end_sim;
		if (n_errors == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic [7:0] sb(input logic [5:0] s, input logic [7:0] e);
		logic [7:0] b;
		b = {s[5], 1'b0, s[4], s[3], s[2], s[1], 1'b0, s[0]};
		b[6] = |(b & e & 8'hbf);
		return b;
	endfunction
	task automatic write_en(input logic [7:0] d);
		@(posedge clk_i);
		enable_wr_i <= 1'b1;
		enable_data_i <= d;
		@(posedge clk_i);
		enable_wr_i <= 1'b0;
		en = d & 8'hbf;
		#1 check(enable_o, en);
	endtask
	task automatic query(input logic [5:0] s, input int n);
		logic [7:0] e;
		@(posedge clk_i);
		src <= s;
		@(posedge clk_i);
		stb_query_i <= 1'b1;
		e = sb(s, en);
		#1 check(service_summary_byte_o, e);
		check({7'h00, service_request_o}, {7'h00, e[6]});
		repeat (n) begin
			exp_q.push_back(e);
			@(posedge clk_i);
		end
		stb_query_i <= 1'b0;
	endtask
	task automatic cmd(input status_byte_pkg::cmd_kind_type k, input logic st);
		@(posedge clk_i);
		cmd_valid_i <= 1'b1;
		cmd_kind_i <= k;
		cmd_self_test_i <= st;
		// Held until an edge samples ready high; a hang ends at the cycle ceiling
		do @(posedge clk_i); while (cmd_ready_o !== 1'b1);
		cmd_valid_i <= 1'b0;
		cmd_self_test_i <= 1'b0;
	endtask
	always @(posedge clk_i) begin
		if (stb_valid_o === 1'b1 || oq_push_o === 1'b1) begin
			if (exp_q.size() == 0) check(8'hee, 8'h00);
			else check(stb_valid_o === 1'b1 ? stb_data_o : oq_data_o, exp_q.pop_front());
		end
		if (bus_trigger_o === 1'b1) n_trg++;
		if (initiate_o === 1'b1) n_init++;
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			end_sim();
		end
	end
	initial begin
		void'($urandom(32'h4e26e515));
		repeat (10) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		#1 check(enable_o, 8'h00);
		check({7'h00, cmd_ready_o}, 8'h01);
		for (int i = 0; i < 6; i++) begin
			write_en(8'hff);
			query(6'h01 << i, 1);
		end
		for (int i = 0; i < 24; i++) begin
			r = $urandom;
			if (i % 3 == 0) write_en(r[7:0]);
			query(r[13:8], 1 + i % 2);
		end
		query(6'h00, 1);
		cmd(status_byte_pkg::CMD_SEQ, 1'b0);
		repeat (4) @(posedge clk_i);
		#1 check({7'h00, cmd_ready_o}, 8'h00);
		@(posedge clk_i);
		seq_done_i <= 1'b1;
		@(posedge clk_i);
		seq_done_i <= 1'b0;
		exp_q.push_back(8'h30);
		cmd(status_byte_pkg::CMD_SEQ, 1'b1);
		repeat (30) @(posedge clk_i);
		cmd(status_byte_pkg::CMD_TRG, 1'b0);
		repeat (3) @(posedge clk_i);
		check(n_trg[7:0], 8'h00);
		source_is_bus_i <= 1'b1;
		cmd(status_byte_pkg::CMD_TRG, 1'b0);
		cmd(status_byte_pkg::CMD_WAI, 1'b0);
		#1 check({7'h00, cmd_ready_o}, 8'h00);
		check(n_trg[7:0], 8'h01);
		@(posedge clk_i);
		bus_get_i <= 1'b1;
		@(posedge clk_i);
		bus_get_i <= 1'b0;
		repeat (12) @(posedge clk_i);
		#1 check(n_trg[7:0], 8'h02);
		cmd(status_byte_pkg::CMD_INIT, 1'b0);
		cmd(status_byte_pkg::CMD_WAI, 1'b0);
		repeat (4) @(posedge clk_i);
		#1 check({7'h00, cmd_ready_o}, 8'h00);
		check({7'h00, model_idle_i}, 8'h00);
		check(n_init[7:0], 8'h01);
		cmd(status_byte_pkg::CMD_WAI, 1'b0);
		#1 check({7'h00, cmd_ready_o}, 8'h01);
		check({7'h00, model_idle_i}, 8'h01);
		repeat (20) @(posedge clk_i);
		check(8'(exp_q.size()), 8'h00);
		end_sim();
	end
endmodule
`default_nettype wire

// file: dv/trigger_model_stub.sv
// Far-side trigger model stand-in: run and pointer-settle status
`default_nettype none
module trigger_model_stub #(
	parameter int IDLE_WAIT = 12,
	parameter int SETTLE_WAIT = 6
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Pulses from the block
	input wire logic initiate_i,
	input wire logic trigger_i,
	// Status back to the block
	output logic model_idle_o,
	output logic pointer_settled_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int busy_cnt;
	int move_cnt;
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			busy_cnt <= 0;
			move_cnt <= 0;
		end else begin
			busy_cnt <= initiate_i ? IDLE_WAIT : (busy_cnt > 0 ? busy_cnt - 1 : 0);
			move_cnt <= trigger_i ? SETTLE_WAIT : (move_cnt > 0 ? move_cnt - 1 : 0);
		end
	end
	// Slow on purpose so a hold-off is visible
	assign model_idle_o = (busy_cnt == 0);
	assign pointer_settled_o = (move_cnt == 0);
endmodule
`default_nettype wire
